// File: qsf_fifo.sv
// Transmit FIFO with parameterised width and depth, valid and ready on both sides
`timescale 1ns/10ps
module qsf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import qsf_pkg::*;
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid & in_ready;
    wire pull = out_valid & out_ready;
    wire [AW:0] cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pull);

    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    always_ff @(posedge clk) begin
        if (push)
            mem_q[wr_q] <= in_data;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
        end else begin
            wr_q <= wr_q + AW'(push);
            rd_q <= rd_q + AW'(pull);
            cnt_q <= cnt_d;
            in_ready <= (cnt_d < (AW+1)'(DEPTH));
        end
    end
endmodule

// File: qsf_flash_model.sv
// Serial flash model: single-line command and address, quad page data, quad read
`timescale 1ns/10ps
module qsf_flash_model (
    input wire logic sck,
    input wire logic nss_n,
    input wire logic [3:0] io,
    input wire logic quad_rd,
    input wire logic [15:0] mword,
    input wire logic [31:0] qdata,
    output logic [3:0] drv,
    output logic [3:0] drv_oe
);
    import qsf_pkg::*;
    logic [7:0] got[$];
    logic [7:0] sr = 8'h00;
    logic [7:0] cmd = 8'h00;
    logic seen = 1'b0;
    int cnt = 0;
    int oi = 0;
    wire quad_wr = cmd == QUAD_PAGE_PROGRAM_COMMAND && cnt >= 32;
    always @(negedge nss_n) begin
        cnt = 0;
        oi = 0;
        seen = 1'b0;
        cmd = 8'h00;
    end
    always @(posedge sck) begin
        if (!nss_n) begin
            seen = 1'b1;
            if (quad_wr && !quad_rd) begin
                sr = {sr[3:0], io};
                cnt = cnt + 4;
            end else begin
                sr = {sr[6:0], io[0]};
                cnt = cnt + 1;
            end
            if (cnt % 8 == 0) begin
                if (cnt == 8) cmd = sr;
                if (got.size() < 260) got.push_back(sr);
            end
        end
    end
    // Advance only after a sampling edge, so idle-high clocks keep the first bit
    always @(negedge sck) begin
        if (!nss_n && seen) oi = oi + 1;
    end
    assign drv = quad_rd ? qdata[31 - 4 * (oi % 8) -: 4] : {2'b00, mword[15 - (oi % 16)], 1'b0};
    assign drv_oe = nss_n ? 4'h0 : quad_rd ? 4'hf : quad_wr ? 4'h0 : 4'h2;
endmodule

// File: qsf_pkg.sv
// Package: shared types and constants of the quad-capable serial peripheral
package qsf_pkg;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam logic [9:0] HALF_MIN = 10'h004;
    localparam logic [4:0] BITS_NARROW = 5'h08;
    localparam logic [4:0] BITS_WIDE = 5'h10;
    localparam logic [4:0] BITS_QUAD = 5'h02;
    localparam logic [5:0] SYNC_RESET = 6'h20;
    localparam logic [7:0] QUAD_PAGE_PROGRAM_COMMAND = 8'h32;
    localparam int FLASH_ADDR_BITS = 24;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01
    } qsf_state_type;

    typedef struct packed {
        logic enable;
        logic master;
        logic clock_idle_polarity;
        logic clock_sample_phase;
        logic lsb_first;
        logic frame16;
        logic rx_only;
        logic crc_en;
        logic quad_en;
        logic quad_write;
        logic nss_soft;
        logic nss_soft_level;
        logic nss_drive;
        logic [2:0] baud;
        logic tx_dma_en;
        logic rx_dma_en;
    } qsf_ctrl_type;

    typedef struct packed {
        logic tx_empty;
        logic rx_full;
        logic busy;
        logic overrun;
        logic crc_err;
        logic mode_fault;
    } qsf_status_type;

    localparam qsf_status_type STATUS_RESET = 6'h20;
endpackage

// File: qsf_spi.sv
// Serial peripheral engine: master and slave, quad-line master frames, CRC, flags
`timescale 1ns/10ps
// Function
// R1 - Quad lines usable only as bus master
// R2 - Quad mode uses six pins
// R3 - Quad write drives all four, read samples
// R4 - Quad frame keeps polarity, two clocks only
// R5 - Quad frame length fixed at eight bits
// R6 - Chip select low means device selected
// R7 - Separate sixteen-bit transmit and receive buffers
// R8 - Normal frame size eight or sixteen bits
// R9 - Software picks MSB-first or LSB-first order
// R10 - Programmable bit rate, polarity and phase
// R11 - Hardware CRC appended on transmit, checked on receive
// R12 - Mode fault, overrun, CRC error flags
// R13 - Transmit and receive buffer status flags
// R14 - Busy flag while transfer in progress
// R15 - DMA requests move transmit and receive data
// R16 - Chip select by software or hardware
// R17 - Three-line full duplex, two-line simplex
// R18 - Page write: select, command, address single-line
// R19 - Then quad write mode shifts page data
// R20 - Deselect, then quad off, then wait
// R21 - Only memory data uses quad mode
// R22 - Flash erases sectors, programs pages
// R23 - Quad frame: upper nibble first, lines 3..0
module qsf_spi (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire qsf_pkg::qsf_ctrl_type CTRL,
    input wire logic [15:0] CRC_POLY,
    input wire logic CRC_NEXT,
    input wire logic FLAG_CLEAR,
    input wire logic [qsf_pkg::DATA_W-1:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    output logic [qsf_pkg::DATA_W-1:0] RX_DATA,
    input wire logic RX_READ,
    output qsf_pkg::qsf_status_type STATUS,
    output logic TX_DMA_REQ,
    output logic RX_DMA_REQ,
    input wire logic SCK_I,
    output logic SCK_O,
    output logic SCK_OE,
    input wire logic NSS_I,
    output logic NSS_O,
    output logic NSS_OE,
    input wire logic [3:0] IO_I,
    output logic [3:0] IO_O,
    output logic [3:0] IO_OE
);
    import qsf_pkg::*;

    qsf_state_type st_q;
    qsf_state_type st_d;
    qsf_status_type status_d;
    logic [15:0] sh_q;
    logic [15:0] sh_d;
    logic [15:0] tx_word_q;
    logic [15:0] tx_crc_q;
    logic [15:0] rx_crc_q;
    logic [5:0] edges_q;
    logic [9:0] div_q;
    logic [5:0] sync_lvl;
    logic sck_q;
    logic sck_prev_q;
    logic fquad_q;
    logic f16_q;
    logic flsb_q;
    logic fmaster_q;
    logic fcrc_q;
    logic crc_pend_q;
    logic fifo_valid;
    logic [15:0] fifo_data;

    // Pins from outside pass three flops
    qsf_sync #(.WIDTH(6), .INIT(SYNC_RESET)) u_sync (
        .clk(CLOCK),
        .rst_n(RSTN),
        .din({NSS_I, SCK_I, IO_I}),
        .level(sync_lvl)
    );

    wire [3:0] s_io = sync_lvl[3:0];
    wire s_sck = sync_lvl[4];
    wire s_nss = sync_lvl[5];

    // Decoding of mode and start conditions
    wire quad_on = CTRL.quad_en & CTRL.master; // R1
    wire selected = CTRL.nss_soft ? ~CTRL.nss_soft_level : ~s_nss; // R6 R16
    wire mf_set = CTRL.enable & CTRL.master & ~CTRL.nss_soft & ~CTRL.nss_drive & ~s_nss; // R12
    wire run_m = CTRL.enable & CTRL.master & ~STATUS.mode_fault;
    wire shifting = (st_q == ST_SHIFT);
    wire m_start = run_m & ~mf_set & (crc_pend_q | fifo_valid);
    wire s_start = CTRL.enable & ~CTRL.master & selected;
    wire start = ~shifting & (m_start | s_start);
    wire pop = start & ~crc_pend_q & fifo_valid; // R15
    wire [15:0] fifo_word = fifo_valid ? fifo_data : 16'h0000;
    wire [15:0] load_w = crc_pend_q ? tx_crc_q : fifo_word; // R11
    wire [4:0] nbits = quad_on ? BITS_QUAD : (CTRL.frame16 ? BITS_WIDE : BITS_NARROW); // R5 R8
    wire [9:0] half_m1 = (HALF_MIN << CTRL.baud) - 10'h001; // R10

    // Edge generation: divider in master role, sampled pin clock in slave role
    wire div_wrap = (div_q == half_m1);
    wire s_edge = (s_sck != sck_prev_q);
    wire deselect = ~fmaster_q & ~selected;
    wire tick = shifting & (fmaster_q ? div_wrap : (s_edge & selected));
    wire lead_m = (sck_q == CTRL.clock_idle_polarity);
    wire lead_s = (s_sck != CTRL.clock_idle_polarity);
    wire lead = fmaster_q ? lead_m : lead_s;
    wire samp = lead ^ CTRL.clock_sample_phase; // R10
    wire launch = tick & ~samp;
    wire last = tick & (edges_q == 6'h01);

    // Shift paths for single line, both orders, and quad nibbles
    wire in_bit = fmaster_q ? s_io[1] : s_io[0]; // R17
    wire [15:0] sh_lsb = f16_q ? {in_bit, sh_q[15:1]} : {8'h00, in_bit, sh_q[7:1]}; // R9
    wire [15:0] sh_single = flsb_q ? sh_lsb : {sh_q[14:0], in_bit}; // R9
    wire [15:0] sh_in = fquad_q ? {sh_q[11:0], s_io} : sh_single; // R3 R23
    wire [15:0] rx_raw = (tick & samp) ? sh_in : sh_q;
    wire [15:0] rx_word = f16_q ? rx_raw : {8'h00, rx_raw[7:0]}; // R5 R8
    wire crc_bad = fcrc_q & (rx_word != rx_crc_q); // R11
    wire data_end = last & ~fcrc_q;
    wire ovr_set = data_end & STATUS.rx_full & ~RX_READ; // R12
    wire rx_store = data_end & ~ovr_set;

    // Output lane enables per role and mode
    wire [3:0] m_oe = quad_on ? {4{CTRL.quad_write}} : {3'b000, ~CTRL.rx_only}; // R2 R3 R17
    wire [3:0] s_oe = (selected & ~CTRL.rx_only) ? 4'h2 : 4'h0; // R17
    wire [3:0] oe_d = run_m ? m_oe : ((CTRL.enable & ~CTRL.master) ? s_oe : 4'h0);

    function automatic logic [3:0] out_bits(input logic [15:0] s, input logic q,
                                            input logic l, input logic w, input logic m);
        logic b;
        b = l ? s[0] : (w ? s[15] : s[7]);
        if (q)
            return s[7:4];
        return m ? {3'b000, b} : {2'b00, b, 1'b0};
    endfunction

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d,
                                             input logic w, input logic [15:0] poly);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            if (w || i < 8) begin
                fb = (w ? r[15] : r[7]) ^ d[i];
                r = {r[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
            end
        end
        return w ? r : {8'h00, r[7:0]};
    endfunction

    always_comb begin
        st_d = st_q;
        if (start)
            st_d = ST_SHIFT;
        else if (last | (shifting & deselect) | ~CTRL.enable)
            st_d = ST_IDLE;
    end

    assign sh_d = start ? load_w : ((tick & samp) ? sh_in : sh_q);

    // Frame engine
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            st_q <= ST_IDLE;
            sh_q <= 16'h0000;
            edges_q <= 6'h00;
            div_q <= 10'h000;
        end else begin
            st_q <= st_d;
            sh_q <= sh_d;
            edges_q <= start ? {nbits, 1'b0} : (tick ? edges_q - 6'h01 : edges_q); // R4
            div_q <= (~shifting | div_wrap) ? 10'h000 : div_q + 10'h001;
        end
    end

    // Shift mode is fixed per frame, so quad shifting switches only between frames; IO_OE follows quad_on on the next clock
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            fquad_q <= 1'b0;
            f16_q <= 1'b0;
            flsb_q <= 1'b0;
            fmaster_q <= 1'b0;
            fcrc_q <= 1'b0;
            tx_word_q <= 16'h0000;
        end else if (start) begin
            fquad_q <= quad_on; // R18 R19 R20 R21
            f16_q <= CTRL.frame16 & ~quad_on; // R5
            flsb_q <= CTRL.lsb_first & ~quad_on;
            fmaster_q <= CTRL.master;
            fcrc_q <= crc_pend_q;
            tx_word_q <= load_w;
        end
    end

    // Serial clock, data lanes and chip select
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            sck_q <= 1'b0;
            sck_prev_q <= 1'b0;
            IO_O <= 4'h0;
            IO_OE <= 4'h0;
            SCK_OE <= 1'b0;
            NSS_O <= 1'b1;
            NSS_OE <= 1'b0;
        end else begin
            sck_q <= (shifting & fmaster_q) ? (sck_q ^ tick) : CTRL.clock_idle_polarity; // R4 R10
            sck_prev_q <= s_sck;
            if (start)
                IO_O <= out_bits(load_w, quad_on, CTRL.lsb_first & ~quad_on,
                                 CTRL.frame16 & ~quad_on, CTRL.master); // R23
            else if (launch)
                IO_O <= out_bits(sh_q, fquad_q, flsb_q, f16_q, fmaster_q); // R3 R23
            IO_OE <= oe_d; // R2 R3
            SCK_OE <= run_m;
            NSS_OE <= CTRL.enable & CTRL.master & CTRL.nss_drive; // R16
            NSS_O <= CTRL.nss_soft ? CTRL.nss_soft_level : (st_d != ST_SHIFT); // R6 R16
        end
    end

    assign SCK_O = sck_q;

    // CRC accumulators and pending CRC frame
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            tx_crc_q <= 16'h0000;
            rx_crc_q <= 16'h0000;
            crc_pend_q <= 1'b0;
        end else begin
            if (~CTRL.crc_en | (last & fcrc_q)) begin
                tx_crc_q <= 16'h0000;
                rx_crc_q <= 16'h0000;
            end else if (data_end) begin
                tx_crc_q <= crc_step(tx_crc_q, tx_word_q, f16_q, CRC_POLY); // R11
                rx_crc_q <= crc_step(rx_crc_q, rx_word, f16_q, CRC_POLY); // R11
            end
            crc_pend_q <= CTRL.crc_en & ((crc_pend_q & ~start) | CRC_NEXT); // R11
        end
    end

    // Status flags: a set wins over a clear in the same cycle
    assign status_d.tx_empty = ~fifo_valid & ~crc_pend_q; // R13
    assign status_d.rx_full = rx_store | (STATUS.rx_full & ~RX_READ); // R13
    assign status_d.busy = shifting; // R14
    assign status_d.overrun = ovr_set | (STATUS.overrun & ~FLAG_CLEAR); // R12
    assign status_d.crc_err = (last & crc_bad) | (STATUS.crc_err & ~FLAG_CLEAR); // R11 R12
    assign status_d.mode_fault = mf_set | (STATUS.mode_fault & ~FLAG_CLEAR); // R12

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            STATUS <= STATUS_RESET;
            RX_DATA <= 16'h0000;
            TX_DMA_REQ <= 1'b0;
            RX_DMA_REQ <= 1'b0;
        end else begin
            STATUS <= status_d;
            if (rx_store)
                RX_DATA <= rx_word; // R7
            TX_DMA_REQ <= CTRL.tx_dma_en & TX_READY; // R15
            RX_DMA_REQ <= CTRL.rx_dma_en & status_d.rx_full; // R15
        end
    end

    // Transmit buffer with back-pressure on the source
    qsf_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLOCK),
        .rst_n(RSTN),
        .in_valid(TX_VALID),
        .in_ready(TX_READY),
        .in_data(TX_DATA),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    property p_quad_master;
        shifting & fquad_q |-> fmaster_q;
    endproperty
    a_quad_master: assert property (p_quad_master) else $error("quad frame outside master"); // R1

    property p_quad_lanes;
        run_m & quad_on |=> IO_OE == {4{$past(CTRL.quad_write)}};
    endproperty
    a_quad_lanes: assert property (p_quad_lanes) else $error("quad lane enables wrong"); // R3

    sequence s_quad_start;
        start & quad_on;
    endsequence
    sequence s_four_edges;
        shifting & (edges_q == 6'h04);
    endsequence
    property p_quad_two_clocks;
        s_quad_start |=> s_four_edges;
    endproperty
    a_quad_two_clocks: assert property (p_quad_two_clocks) else $error("quad edge count"); // R4

    property p_quad_byte;
        last & fquad_q |-> rx_word[15:8] == 8'h00;
    endproperty
    a_quad_byte: assert property (p_quad_byte) else $error("quad frame wider than byte"); // R5

    property p_upper_nibble;
        s_quad_start |=> IO_O == $past(load_w[7:4]);
    endproperty
    a_upper_nibble: assert property (p_upper_nibble) else $error("upper nibble not first"); // R23

    property p_hw_select;
        !$past(CTRL.nss_soft) & shifting |-> !NSS_O;
    endproperty
    a_hw_select: assert property (p_hw_select) else $error("select high during frame"); // R6

    property p_busy;
        start & CTRL.master |-> ##2 STATUS.busy [*3];
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag missing"); // R14

    property p_overrun;
        ovr_set |=> STATUS.overrun & STATUS.rx_full;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // R12

    property p_rx_store;
        data_end & !STATUS.rx_full |=> STATUS.rx_full && RX_DATA == $past(rx_word);
    endproperty
    a_rx_store: assert property (p_rx_store) else $error("receive word not held"); // R13

    property p_crc_flag;
        last & crc_bad |=> STATUS.crc_err;
    endproperty
    a_crc_flag: assert property (p_crc_flag) else $error("CRC mismatch not flagged"); // R11

    property p_half_period;
        tick & fmaster_q & !last |=> !tick [*3];
    endproperty
    a_half_period: assert property (p_half_period) else $error("clock half period short"); // R10
endmodule

// File: qsf_sync.sv
// Three-stage pin synchroniser that reports a level once stages two and three agree
`timescale 1ns/10ps
module qsf_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] level
);
    import qsf_pkg::*;
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] hold_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            hold_q <= INIT;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            hold_q <= level;
        end
    end

    // Agreement shows at once, so a pin is seen three edges after it moves
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        assign level[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : hold_q[i];
    end
endmodule

// File: tb.sv
// Testbench: quad-capable serial peripheral against a serial flash model
`timescale 1ns/10ps
module tb;
    import qsf_pkg::*;
    logic clock = 0, rstn = 0, flag_clear = 0, tx_valid = 0, rx_read = 0, sck_i = 0;
    logic nss_i = 1, s_en = 0, s_mosi = 0, quad_rd = 0, sck_p = 0, crc_next = 0;
    logic tx_ready, tx_dma_req, rx_dma_req, sck_o, sck_oe, nss_o, nss_oe;
    logic [15:0] tx_data = 0, mword = 0, w, rx_data;
    logic [31:0] qdata = 0, seed = 32'd38384;
    logic [3:0] io_i, io_o, io_oe, fl_drv, fl_oe, last_io = 0;
    logic [7:0] b;
    qsf_ctrl_type ctrl = '0;
    qsf_status_type status;
    logic [7:0] exp_q[$];
    int err_total = 0, check_count = 0, cyc = 0, rises = 0, run = 0, half = 0, r0;
    wire fl_nss = nss_oe ? nss_o : 1'b1;
    wire fl_sck = sck_oe ? sck_o : ctrl.clock_idle_polarity;
    qsf_spi qsf_spi_inst (.CLOCK(clock), .RSTN(rstn), .CTRL(ctrl), .CRC_POLY(16'h8005),
        .CRC_NEXT(crc_next), .FLAG_CLEAR(flag_clear), .TX_DATA(tx_data), .TX_VALID(tx_valid),
        .TX_READY(tx_ready), .RX_DATA(rx_data), .RX_READ(rx_read), .STATUS(status),
        .TX_DMA_REQ(tx_dma_req), .RX_DMA_REQ(rx_dma_req), .SCK_I(sck_i), .SCK_O(sck_o),
        .SCK_OE(sck_oe), .NSS_I(nss_i), .NSS_O(nss_o), .NSS_OE(nss_oe), .IO_I(io_i),
        .IO_O(io_o), .IO_OE(io_oe));
    qsf_flash_model qsf_flash_model_inst (.sck(fl_sck), .nss_n(fl_nss), .io(io_i),
        .quad_rd(quad_rd), .mword(mword), .qdata(qdata), .drv(fl_drv), .drv_oe(fl_oe));
    // Released lines show the inverse of their last level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io_i[i] = io_oe[i] ? io_o[i] : fl_oe[i] ? fl_drv[i] : ~last_io[i];
        end
        if (s_en) io_i[0] = s_mosi;
    end
    always @(posedge clock) last_io <= io_i;
    initial begin
        forever #10 clock = ~clock;
    end
    always @(negedge clock) begin
        cyc++;
        run++;
        if (sck_o !== sck_p) begin
            half = run;
            run = 0;
            if (sck_o === 1'b1) rises++;
        end
        sck_p = sck_o;
        if (cyc == 30000) begin
            err_total++;
            give_verdict();
        end
    end
    function logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    function logic [7:0] crc8(input logic [7:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h05 : 8'h00);
        end
        return c;
    endfunction
    function qsf_ctrl_type mst(input logic [2:0] bd);
        qsf_ctrl_type c;
        c = '0;
        c.enable = 1'b1;
        c.master = 1'b1;
        c.nss_soft = 1'b1;
        c.nss_drive = 1'b1;
        c.baud = bd;
        return c;
    endfunction
    task give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task chk1(input logic g, input logic e);
        chk({15'h0000, g}, {15'h0000, e});
    endtask
    task step(input int n);
        repeat (n) @(negedge clock);
    endtask
    task push(input logic [15:0] d);
        int k;
        k = 0;
        while (tx_ready !== 1'b1 && k < 3000) begin
            tx_valid = 1'b0;
            k++;
            @(negedge clock);
        end
        tx_data = d;
        tx_valid = 1'b1;
        @(negedge clock);
    endtask
    task wait_idle();
        int k;
        int n;
        k = 0;
        n = 0;
        while (n < 6 && k < 20000) begin
            @(negedge clock);
            k++;
            if (status.busy === 1'b0 && status.tx_empty === 1'b1) n++;
            else n = 0;
        end
        step(2);
    endtask
    task cmp_bytes();
        chk(16'(qsf_flash_model_inst.got.size()), 16'(exp_q.size()));
        foreach (exp_q[i]) chk({8'h00, qsf_flash_model_inst.got[i]}, {8'h00, exp_q[i]});
        exp_q.delete();
    endtask
    task desel();
        ctrl.nss_soft_level = 1'b1;
        step(2);
        qsf_flash_model_inst.got.delete();
    endtask
    task rd_clear();
        rx_read = 1'b1;
        flag_clear = 1'b1;
        step(1);
        rx_read = 1'b0;
        flag_clear = 1'b0;
        step(2);
    endtask
    initial begin
        step(16);
        rstn = 1'b1;
        step(2);
        chk({10'h000, status}, {10'h000, STATUS_RESET});
        chk1(nss_o, 1'b1);
        chk1(tx_ready, 1'b1);
        mword = rnd();
        ctrl = mst(3'd0);
        ctrl.enable = 1'b0;
        ctrl.tx_dma_en = 1'b1;
        ctrl.rx_dma_en = 1'b1;
        step(2);
        chk1(tx_dma_req, 1'b1);
        repeat (8) begin
            w = rnd() | 16'h0080;
            exp_q.push_back(w[7:0]);
            push(w);
        end
        tx_valid = 1'b0;
        step(2);
        chk1(tx_ready, 1'b0);
        chk1(tx_dma_req, 1'b0);
        tx_data = 16'h00aa;
        tx_valid = 1'b1;
        step(3);
        tx_valid = 1'b0;
        r0 = rises;
        ctrl.enable = 1'b1;
        wait_idle();
        chk(16'(rises - r0), 16'd64);
        chk(16'(half), 16'd4);
        cmp_bytes();
        chk1(status.overrun, 1'b1);
        chk1(status.rx_full, 1'b1);
        chk1(rx_dma_req, 1'b1);
        chk(rx_data, {8'h00, mword[15:8]});
        rd_clear();
        chk1(status.overrun, 1'b0);
        chk1(status.rx_full, 1'b0);
        desel();
        $display("fifo and overrun test done");
        ctrl.nss_soft_level = 1'b0;
        step(2);
        chk1(nss_o, 1'b0);
        qdata = {rnd(), rnd()};
        for (int i = 3; i >= 0; i--) begin
            b = i == 3 ? QUAD_PAGE_PROGRAM_COMMAND : qdata[8 * i +: 8];
            exp_q.push_back(b);
            push({8'h00, b});
        end
        tx_valid = 1'b0;
        wait_idle();
        ctrl.quad_en = 1'b1;
        ctrl.quad_write = 1'b1;
        r0 = rises;
        repeat (6) begin
            w = rnd();
            exp_q.push_back(w[7:0]);
            push(w);
        end
        tx_valid = 1'b0;
        step(2);
        chk({12'h000, io_oe}, 16'h000f);
        wait_idle();
        chk(16'(rises - r0), 16'd12);
        cmp_bytes();
        rd_clear();
        desel();
        ctrl.quad_en = 1'b0;
        ctrl.quad_write = 1'b0;
        ctrl.nss_soft_level = 1'b0;
        step(1);
        $display("quad page write test done");
        ctrl = mst(3'd1);
        ctrl.clock_idle_polarity = 1'b1;
        ctrl.clock_sample_phase = 1'b1;
        ctrl.frame16 = 1'b1;
        ctrl.lsb_first = 1'b1;
        ctrl.nss_soft_level = 1'b1;
        step(2);
        chk1(sck_o, 1'b1);
        ctrl.nss_soft_level = 1'b0;
        w = rnd();
        mword = rnd();
        r0 = rises;
        push(w);
        tx_valid = 1'b0;
        wait_idle();
        b = {<<{w[7:0]}};
        exp_q.push_back(b);
        b = {<<{w[15:8]}};
        exp_q.push_back(b);
        cmp_bytes();
        w = {<<{mword}};
        chk(rx_data, w);
        chk(16'(rises - r0), 16'd16);
        chk(16'(half), 16'd8);
        rd_clear();
        desel();
        $display("wide lsb first test done");
        ctrl = mst(3'd0);
        ctrl.crc_en = 1'b1;
        mword = rnd();
        step(2);
        w = rnd();
        push(w);
        tx_valid = 1'b0;
        step(3);
        crc_next = 1'b1;
        step(1);
        crc_next = 1'b0;
        wait_idle();
        exp_q.push_back(w[7:0]);
        exp_q.push_back(crc8(w[7:0]));
        cmp_bytes();
        chk(rx_data, {8'h00, mword[15:8]});
        chk1(status.crc_err, crc8(mword[15:8]) != mword[7:0]);
        rd_clear();
        chk1(status.crc_err, 1'b0);
        desel();
        $display("crc test done");
        ctrl = mst(3'd0);
        ctrl.quad_en = 1'b1;
        ctrl.nss_soft_level = 1'b1;
        quad_rd = 1'b1;
        qdata = {rnd(), rnd()};
        step(2);
        ctrl.nss_soft_level = 1'b0;
        for (int k = 0; k < 4; k++) begin
            push(16'h0000);
            tx_valid = 1'b0;
            step(3);
            chk({12'h000, io_oe}, 16'h0000);
            chk1(status.busy, 1'b1);
            wait_idle();
            chk(rx_data, {8'h00, qdata[31 - 8 * k -: 8]});
            rd_clear();
        end
        desel();
        quad_rd = 1'b0;
        ctrl.quad_en = 1'b0;
        $display("quad read test done");
        ctrl.nss_soft = 1'b0;
        ctrl.nss_drive = 1'b0;
        nss_i = 1'b0;
        step(8);
        chk1(status.mode_fault, 1'b1);
        nss_i = 1'b1;
        step(5);
        rd_clear();
        chk1(status.mode_fault, 1'b0);
        ctrl = '0;
        ctrl.enable = 1'b1;
        b = 8'(rnd());
        nss_i = 1'b0;
        s_en = 1'b1;
        @(negedge clock);
        #3;
        for (int i = 7; i >= 0; i--) begin
            s_mosi = b[i];
            #80 sck_i = 1'b1;
            if (i == 4) chk({12'h000, io_oe}, 16'h0002);
            #80 sck_i = 1'b0;
        end
        step(8);
        chk(rx_data, {8'h00, b});
        ctrl.rx_only = 1'b1;
        step(2);
        chk({12'h000, io_oe}, 16'h0000);
        nss_i = 1'b1;
        s_en = 1'b0;
        rd_clear();
        $display("slave test done");
        give_verdict();
    end
endmodule
